// >>> hdl/elapsed_time_meter_pkg.sv
// Purpose: Shared constants and types for the elapsed time meter
// Assumes: 20 MHz system clock, APB register access
// Notes: Byte addresses are chosen offsets, one word per register
package elapsed_time_meter_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLOCK_HZ = 20000000;
  localparam int SECOND_NS = 1000000000;
  localparam int CLOCK_PERIOD_NS = SECOND_NS / CLOCK_HZ;
  localparam int TICKS_PER_SECOND = SECOND_NS / CLOCK_PERIOD_NS;
  localparam int SAVE_INTERVAL_S = 3600;
  // ==========================================================
  // Time fields
  // ==========================================================
  localparam int MAJOR_W = 15;
  localparam int MINOR_W = 6;
  localparam int TICK_W = 25;
  localparam int SAVE_W = 12;
  localparam logic [MINOR_W-1:0] MINOR_LAST = 6'h3b;
  localparam logic [MAJOR_W-1:0] MAJOR_LAST = 15'h7fff;
  localparam logic [MAJOR_W-1:0] MAJOR_ZERO = 15'h0000;
  localparam logic [MINOR_W-1:0] MINOR_ZERO = 6'h00;
  localparam logic [MINOR_W-1:0] MINOR_ONE = 6'h01;
  localparam logic [MAJOR_W-1:0] MAJOR_ONE = 15'h0001;
  localparam logic [TICK_W-1:0] TICK_LAST = 25'(TICKS_PER_SECOND - 1);
  localparam logic [SAVE_W-1:0] SAVE_LAST = 12'(SAVE_INTERVAL_S - 1);
  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SET_TIME = 8'h04;
  localparam logic [7:0] ADDR_CURRENT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_SAVED = 8'h10;
  localparam int CTRL_UNIT_BIT = 0;
  localparam int CTRL_NV_BIT = 1;
  localparam int MINOR_LSB = 0;
  localparam int MAJOR_LSB = 8;
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_SAVE_BIT = 2;
  // Time unit: 0 is hours with minutes, 1 is minutes with seconds
  typedef enum logic {
    UNIT_HOUR_MIN = 1'b0,
    UNIT_MIN_SEC = 1'b1
  } time_unit_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_SAVE = 2'b11
  } meter_state_t;
endpackage

// >>> hdl/tick_divider.sv
// Purpose: One pulse per second from the system clock
// Assumes: Runs only while enabled; restarts at the same phase
// Notes: Holding the phase while stopped keeps partial seconds
`timescale 1ns/1ps
module tick_divider #(
  parameter logic [elapsed_time_meter_pkg::TICK_W-1:0] TICK_LAST = elapsed_time_meter_pkg::TICK_LAST
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic i_clear,
  output logic o_tick
);
  typedef struct packed {
    logic [elapsed_time_meter_pkg::TICK_W-1:0] count;
  } div_state_t;
  div_state_t state;
  div_state_t next_state;
  // ==========================================================
  // Divider
  // ==========================================================
  always_comb begin
    next_state = state;
    if (i_clear) begin
      next_state.count = '0;
    end else if (i_enable) begin
      if (state.count == TICK_LAST) begin
        next_state.count = '0;
      end else begin
        next_state.count = state.count + 25'h0000001;
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign o_tick = i_enable && !i_clear && (state.count == TICK_LAST);
endmodule // tick_divider

// >>> hdl/time_compare.sv
// Purpose: Reached test of current time against set time
// Assumes: Both values in the same unit
// Notes: Pure comparator, major field weighs first
`timescale 1ns/1ps
module time_compare (
  input wire logic [14:0] i_cur_major,
  input wire logic [5:0] i_cur_minor,
  input wire logic [14:0] i_set_major,
  input wire logic [5:0] i_set_minor,
  output logic o_reached
);
  assign o_reached = {i_cur_major, i_cur_minor} >= {i_set_major, i_set_minor};
endmodule // time_compare

// >>> hdl/elapsed_time_meter.sv
// Purpose: Operating time accumulator with set time output
// Assumes: APB slave, 20 MHz clock, external nonvolatile store
// Notes: Saved total is offered on a port with a write strobe
//==============================================================
`timescale 1ns/1ps
module elapsed_time_meter #(
  parameter int INSTANCE_NUMBER = 197,
  parameter logic [11:0] SAVE_INTERVAL = elapsed_time_meter_pkg::SAVE_LAST,
  // Cycles per second minus one; shortened only for simulation
  parameter logic [24:0] TICK_LAST = elapsed_time_meter_pkg::TICK_LAST
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic i_power_fail,
  input wire logic i_restore_valid,
  input wire logic [14:0] i_restore_major,
  input wire logic [5:0] i_restore_minor,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic o_out,
  output logic o_unit,
  output logic [14:0] o_set_major,
  output logic [5:0] o_set_minor,
  output logic [14:0] o_cur_major,
  output logic [5:0] o_cur_minor,
  output logic o_save_strobe,
  output logic [14:0] o_save_major,
  output logic [5:0] o_save_minor
);
  localparam logic NV_CAPABLE = (INSTANCE_NUMBER >= 197) && (INSTANCE_NUMBER <= 200);
  typedef struct packed {
    elapsed_time_meter_pkg::meter_state_t fsm;
    elapsed_time_meter_pkg::time_unit_t unit;
    logic nv_enable;
    logic [14:0] set_major;
    logic [5:0] set_minor;
    logic [14:0] cur_major;
    logic [5:0] cur_minor;
    logic [5:0] sub_minor;
    logic [11:0] save_count;
    logic power_fail_seen;
    logic out;
    logic save_strobe;
    logic [14:0] save_major;
    logic [5:0] save_minor;
    logic [31:0] rdata;
    logic err;
  } meter_t;
  meter_t state;
  meter_t next_state;
  logic tick;
  logic reached;
  logic access;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;
  logic [14:0] wr_major;
  logic [5:0] wr_minor;
  // ==========================================================
  // Second divider and comparator
  // ==========================================================
  tick_divider #(
    .TICK_LAST(TICK_LAST)
  ) u_tick (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_enable(i_run),
    .i_clear(i_clear),
    .o_tick(tick)
  );
  time_compare u_cmp (
    .i_cur_major(state.cur_major),
    .i_cur_minor(state.cur_minor),
    .i_set_major(state.set_major),
    .i_set_minor(state.set_minor),
    .o_reached(reached)
  );
  // ==========================================================
  // APB decode
  // ==========================================================
  assign access = psel && penable;
  assign wr_major = pwdata[elapsed_time_meter_pkg::MAJOR_LSB +: elapsed_time_meter_pkg::MAJOR_W];
  assign wr_minor = pwdata[elapsed_time_meter_pkg::MINOR_LSB +: elapsed_time_meter_pkg::MINOR_W];
  always_comb begin
    rd_mux = '0;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    case (paddr)
      elapsed_time_meter_pkg::ADDR_CONTROL: begin
        rd_mux[elapsed_time_meter_pkg::CTRL_UNIT_BIT] = state.unit;
        rd_mux[elapsed_time_meter_pkg::CTRL_NV_BIT] = state.nv_enable;
      end
      elapsed_time_meter_pkg::ADDR_SET_TIME: begin
        rd_mux[elapsed_time_meter_pkg::MAJOR_LSB +: elapsed_time_meter_pkg::MAJOR_W] = state.set_major;
        rd_mux[elapsed_time_meter_pkg::MINOR_LSB +: elapsed_time_meter_pkg::MINOR_W] = state.set_minor;
        // Minor field above 59 refused so the compare stays meaningful
        wr_ok = (wr_minor <= elapsed_time_meter_pkg::MINOR_LAST);
      end
      elapsed_time_meter_pkg::ADDR_CURRENT: begin
        rd_mux[elapsed_time_meter_pkg::MAJOR_LSB +: elapsed_time_meter_pkg::MAJOR_W] = state.cur_major;
        rd_mux[elapsed_time_meter_pkg::MINOR_LSB +: elapsed_time_meter_pkg::MINOR_W] = state.cur_minor;
        wr_ok = 1'b0;
      end
      elapsed_time_meter_pkg::ADDR_STATUS: begin
        rd_mux[elapsed_time_meter_pkg::STAT_OUT_BIT] = state.out;
        rd_mux[elapsed_time_meter_pkg::STAT_RUN_BIT] = i_run;
        rd_mux[elapsed_time_meter_pkg::STAT_SAVE_BIT] = state.power_fail_seen;
        wr_ok = 1'b0;
      end
      elapsed_time_meter_pkg::ADDR_SAVED: begin
        rd_mux[elapsed_time_meter_pkg::MAJOR_LSB +: elapsed_time_meter_pkg::MAJOR_W] = state.save_major;
        rd_mux[elapsed_time_meter_pkg::MINOR_LSB +: elapsed_time_meter_pkg::MINOR_W] = state.save_minor;
        wr_ok = 1'b0;
      end
      default: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end
  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_state = state;
    next_state.save_strobe = 1'b0;
    // Bus side
    // Read word taken in setup so it stands through the access phase
    if (psel && !penable && !pwrite) begin
      next_state.rdata = rd_ok ? rd_mux : 32'h00000000;
    end
    if (access) begin
      next_state.err = pwrite ? !wr_ok : !rd_ok;
      if (pwrite && wr_ok) begin
        case (paddr)
          elapsed_time_meter_pkg::ADDR_CONTROL: begin
            next_state.unit = elapsed_time_meter_pkg::time_unit_t'(
              pwdata[elapsed_time_meter_pkg::CTRL_UNIT_BIT]);
            next_state.nv_enable = pwdata[elapsed_time_meter_pkg::CTRL_NV_BIT] && NV_CAPABLE;
          end
          elapsed_time_meter_pkg::ADDR_SET_TIME: begin
            next_state.set_major = wr_major;
            next_state.set_minor = wr_minor;
          end
          default: begin
            next_state.err = 1'b0;
          end
        endcase
      end
    end
    // Counting, with carry at sixty
    if (i_clear) begin
      next_state.cur_major = elapsed_time_meter_pkg::MAJOR_ZERO;
      next_state.cur_minor = elapsed_time_meter_pkg::MINOR_ZERO;
      next_state.sub_minor = elapsed_time_meter_pkg::MINOR_ZERO;
    // Control bit resets low, so only the instance capability gates restore
    end else if (state.fsm == elapsed_time_meter_pkg::ST_IDLE && i_restore_valid && NV_CAPABLE) begin
      next_state.cur_major = i_restore_major;
      next_state.cur_minor = i_restore_minor;
    end else if (tick) begin
      // Hour:minute unit counts sixty seconds per minute step
      if (state.unit == elapsed_time_meter_pkg::UNIT_HOUR_MIN &&
          state.sub_minor != elapsed_time_meter_pkg::MINOR_LAST) begin
        next_state.sub_minor = state.sub_minor + elapsed_time_meter_pkg::MINOR_ONE;
      end else begin
        next_state.sub_minor = elapsed_time_meter_pkg::MINOR_ZERO;
        if (state.cur_minor == elapsed_time_meter_pkg::MINOR_LAST) begin
          next_state.cur_minor = elapsed_time_meter_pkg::MINOR_ZERO;
          // Saturate at top of range rather than wrapping to zero
          if (state.cur_major != elapsed_time_meter_pkg::MAJOR_LAST) begin
            next_state.cur_major = state.cur_major + elapsed_time_meter_pkg::MAJOR_ONE;
          end else begin
            next_state.cur_minor = elapsed_time_meter_pkg::MINOR_LAST;
          end
        end else begin
          next_state.cur_minor = state.cur_minor + elapsed_time_meter_pkg::MINOR_ONE;
        end
      end
    end
    // Held value when not running needs no code: no tick, no change.
    next_state.out = reached;
    // Nonvolatile save control
    next_state.power_fail_seen = state.power_fail_seen || i_power_fail;
    case (state.fsm)
      elapsed_time_meter_pkg::ST_IDLE: begin
        next_state.fsm = elapsed_time_meter_pkg::ST_RUN;
      end
      elapsed_time_meter_pkg::ST_RUN: begin
        if (tick && state.save_count != SAVE_INTERVAL) begin
          next_state.save_count = state.save_count + 12'h001;
        end
        // Limited write endurance: save at power down or interval only
        if (state.nv_enable && ((i_power_fail && !state.power_fail_seen) ||
            (tick && state.save_count == SAVE_INTERVAL))) begin
          next_state.fsm = elapsed_time_meter_pkg::ST_SAVE;
          next_state.save_count = '0;
        end
      end
      elapsed_time_meter_pkg::ST_SAVE: begin
        next_state.save_strobe = 1'b1;
        next_state.save_major = state.cur_major;
        next_state.save_minor = state.cur_minor;
        next_state.fsm = elapsed_time_meter_pkg::ST_RUN;
      end
      default: begin
        next_state.fsm = elapsed_time_meter_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  // ==========================================================
  // Outputs
  // ==========================================================
  assign pready = 1'b1;
  assign prdata = state.rdata;
  assign pslverr = access && (pwrite ? !wr_ok : !rd_ok);
  assign o_out = state.out;
  assign o_unit = state.unit;
  assign o_set_major = state.set_major;
  assign o_set_minor = state.set_minor;
  assign o_cur_major = state.cur_major;
  assign o_cur_minor = state.cur_minor;
  assign o_save_strobe = state.save_strobe;
  assign o_save_major = state.save_major;
  assign o_save_minor = state.save_minor;
endmodule // elapsed_time_meter

// >>> verif/elapsed_time_meter_monitor.sv
// Purpose: Port checker for the elapsed time meter
// Assumes: One clock, async active-low reset
// Notes: Counting is checked through its effects on the ports
`timescale 1ns/1ps
module elapsed_time_meter_monitor (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic i_restore_valid,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic o_out,
  input wire logic [14:0] o_set_major,
  input wire logic [5:0] o_set_minor,
  input wire logic [14:0] o_cur_major,
  input wire logic [5:0] o_cur_minor,
  input wire logic o_save_strobe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic reached;
  assign reached = {o_cur_major, o_cur_minor} >= {o_set_major, o_set_minor};
  // ==========================================================
  // Bus steps
  // ==========================================================
  sequence access_s;
    psel && penable;
  endsequence
  sequence set_write_s;
    access_s ##0 (pwrite && paddr == elapsed_time_meter_pkg::ADDR_SET_TIME);
  endsequence
  a_zero_wait: assert property (access_s |-> pready) else $error("pready low in access phase");
  a_out_follows_reach: assert property ($past(i_rst_b) |-> o_out == $past(reached))
    else $error("out not tracking reach");
  a_clear_zeroes: assert property (i_clear |=> o_cur_major == 15'h0000 && o_cur_minor == 6'h00)
    else $error("clear did not zero current");
  a_hold_stopped: assert property (!i_run && !i_clear && !i_restore_valid |=> $stable({o_cur_major, o_cur_minor}))
    else $error("current moved while stopped");
  a_change_has_cause: assert property (!$stable({o_cur_major, o_cur_minor}) |-> $past(i_run || i_clear || i_restore_valid))
    else $error("current changed without cause");
  a_minor_range: assert property (o_cur_minor <= 6'h3b && o_set_minor <= 6'h3b)
    else $error("minor field above 59");
  a_bad_minor_refused: assert property (set_write_s ##0 pwdata[5:0] > 6'h3b |-> pslverr ##1 $stable(o_set_minor))
    else $error("bad set minor accepted");
  a_set_held: assert property (!(psel && penable && pwrite) |=> $stable({o_set_major, o_set_minor}))
    else $error("set time moved without write");
  a_readonly_refused: assert property (access_s ##0 (pwrite && paddr >= 8'h08) |-> pslverr)
    else $error("read-only write accepted");
  a_save_one_cycle: assert property (o_save_strobe |=> !o_save_strobe) else $error("save strobe too long");
endmodule // elapsed_time_meter_monitor

bind elapsed_time_meter elapsed_time_meter_monitor mon (.i_clock, .i_rst_b, .i_run, .i_clear, .i_restore_valid,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .o_out, .o_set_major, .o_set_minor,
  .o_cur_major, .o_cur_minor, .o_save_strobe);

// >>> verif/input_source.sv
// Purpose: Neighbouring logic feeding run, clear and power-fail
// Assumes: Commands from the bench, one cycle of latency
// Notes: No stored total, so restore data is never valid
`timescale 1ns/1ps
module input_source (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_cmd_run,
  input wire logic i_cmd_clear,
  input wire logic i_cmd_fail,
  output logic o_run,
  output logic o_clear,
  output logic o_power_fail,
  output logic o_restore_valid,
  output logic [14:0] o_restore_major,
  output logic [5:0] o_restore_minor
);
  // Invalid restore lines toggle so a stale value never looks real
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_run <= 1'b0;
      o_clear <= 1'b0;
      o_power_fail <= 1'b0;
      o_restore_valid <= 1'b0;
      o_restore_major <= 15'h2aaa;
      o_restore_minor <= 6'h15;
    end else begin
      o_run <= i_cmd_run;
      o_clear <= i_cmd_clear;
      o_power_fail <= i_cmd_fail;
      o_restore_major <= ~o_restore_major;
      o_restore_minor <= ~o_restore_minor;
    end
  end
endmodule // input_source

// >>> verif/elapsed_time_meter_tb.sv
// Purpose: Register and pin checks for the elapsed time meter
// Assumes: Zero-wait bus, read data taken at the access edge
// Notes: Second shortened to ten cycles so carries are reachable
`timescale 1ns/1ps
module elapsed_time_meter_tb;
  logic i_clock = 1'b0;
  logic i_rst_b;
  logic cmd_run = 1'b0;
  logic cmd_clear = 1'b0;
  logic cmd_fail = 1'b0;
  logic run, clear, power_fail, restore_valid, o_out, o_unit, o_save_strobe;
  logic [14:0] restore_major, o_set_major, o_cur_major, o_save_major;
  logic [5:0] restore_minor, o_set_minor, o_cur_minor, o_save_minor;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  int fails = 0;
  int tests_run = 0;
  always #25 i_clock = ~i_clock;
  input_source src (.i_clock, .i_rst_b, .i_cmd_run(cmd_run), .i_cmd_clear(cmd_clear), .i_cmd_fail(cmd_fail),
    .o_run(run), .o_clear(clear), .o_power_fail(power_fail), .o_restore_valid(restore_valid),
    .o_restore_major(restore_major), .o_restore_minor(restore_minor));
  elapsed_time_meter #(.INSTANCE_NUMBER(197), .SAVE_INTERVAL(12'h002), .TICK_LAST(25'h0000009)) dut (.i_clock,
    .i_rst_b, .i_run(run),
    .i_clear(clear), .i_power_fail(power_fail), .i_restore_valid(restore_valid), .i_restore_major(restore_major),
    .i_restore_minor(restore_minor), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .o_out, .o_unit, .o_set_major, .o_set_minor, .o_cur_major, .o_cur_minor, .o_save_strobe, .o_save_major,
    .o_save_minor);
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic exp_err,
    input logic [31:0] exp_rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    // Only the watchdog ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge i_clock);
    end
    check("pslverr", 32'(pslverr), 32'(exp_err));
    if (!wr) check("prdata", prdata, exp_rd);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask
  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    int n;
    i_rst_b = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    @(posedge i_clock);
    check("out_reset", 32'(o_out), 32'h1);
    xfer(1'b0, elapsed_time_meter_pkg::ADDR_CONTROL, 32'h0, 1'b0, 32'h0);
    xfer(1'b0, elapsed_time_meter_pkg::ADDR_SET_TIME, 32'h0, 1'b0, 32'h0);
    xfer(1'b0, elapsed_time_meter_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h1);
    xfer(1'b1, elapsed_time_meter_pkg::ADDR_SET_TIME, 32'h5, 1'b0, 32'h0);
    repeat (2) @(posedge i_clock);
    check("out_below", 32'(o_out), 32'h0);
    check("set_minor", 32'(o_set_minor), 32'h5);
    xfer(1'b1, elapsed_time_meter_pkg::ADDR_SET_TIME, 32'h007fff3b, 1'b0, 32'h0);
    xfer(1'b1, elapsed_time_meter_pkg::ADDR_SET_TIME, 32'h0000003c, 1'b1, 32'h0);
    xfer(1'b0, elapsed_time_meter_pkg::ADDR_SET_TIME, 32'h0, 1'b0, 32'h007fff3b);
    check("set_major", 32'(o_set_major), 32'h7fff);
    xfer(1'b1, elapsed_time_meter_pkg::ADDR_CURRENT, 32'h0101, 1'b1, 32'h0);
    xfer(1'b0, 8'h14, 32'h0, 1'b1, 32'h0);
    xfer(1'b1, elapsed_time_meter_pkg::ADDR_CONTROL, 32'h1, 1'b0, 32'h0);
    repeat (2) @(posedge i_clock);
    check("unit", 32'(o_unit), 32'h1);
    // A partial second must not show up as a count
    cmd_run <= 1'b1;
    repeat (7) @(posedge i_clock);
    check("cur_partial", {o_cur_major, 2'b00, o_cur_minor}, 32'h0);
    repeat (610) @(posedge i_clock);
    check("cur_carry", {o_cur_major, 2'b00, o_cur_minor}, 32'h0101);
    cmd_run <= 1'b0;
    repeat (20) @(posedge i_clock);
    check("cur_held", {o_cur_major, 2'b00, o_cur_minor}, 32'h0101);
    cmd_run <= 1'b1;
    repeat (10) @(posedge i_clock);
    check("cur_resumed", {o_cur_major, 2'b00, o_cur_minor}, 32'h0102);
    cmd_run <= 1'b0;
    xfer(1'b1, elapsed_time_meter_pkg::ADDR_SET_TIME, 32'h0103, 1'b0, 32'h0);
    repeat (2) @(posedge i_clock);
    check("out_short", 32'(o_out), 32'h0);
    cmd_run <= 1'b1;
    repeat (27) @(posedge i_clock);
    check("out_reached", 32'(o_out), 32'h1);
    check("cur_past_set", {o_cur_major, 2'b00, o_cur_minor}, 32'h0105);
    cmd_clear <= 1'b1;
    repeat (3) @(posedge i_clock);
    check("cur_clear_run", {o_cur_major, 2'b00, o_cur_minor}, 32'h0);
    cmd_run <= 1'b0;
    cmd_clear <= 1'b0;
    xfer(1'b1, elapsed_time_meter_pkg::ADDR_CONTROL, 32'h0, 1'b0, 32'h0);
    cmd_run <= 1'b1;
    repeat (700) @(posedge i_clock);
    check("cur_hour_min", {o_cur_major, 2'b00, o_cur_minor}, 32'h0001);
    cmd_run <= 1'b0;
    cmd_clear <= 1'b1;
    repeat (3) @(posedge i_clock);
    cmd_clear <= 1'b0;
    xfer(1'b0, elapsed_time_meter_pkg::ADDR_CURRENT, 32'h0, 1'b0, 32'h0);
    xfer(1'b1, elapsed_time_meter_pkg::ADDR_CONTROL, 32'h3, 1'b0, 32'h0);
    xfer(1'b0, elapsed_time_meter_pkg::ADDR_CONTROL, 32'h0, 1'b0, 32'h3);
    cmd_fail <= 1'b1;
    n = 0;
    while (o_save_strobe !== 1'b1 && n < 20) begin
      n++;
      @(posedge i_clock);
    end
    check("save_strobe", 32'(o_save_strobe), 32'h1);
    check("save_value", {o_save_major, 2'b00, o_save_minor}, 32'h0);
    xfer(1'b0, elapsed_time_meter_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h4);
    // Third second after the last save triggers the periodic one
    cmd_run <= 1'b1;
    n = 0;
    while (o_save_strobe !== 1'b1 && n < 60) begin
      n++;
      @(posedge i_clock);
    end
    check("save_periodic", 32'(o_save_strobe), 32'h1);
    check("save_interval_value", {o_save_major, 2'b00, o_save_minor}, 32'h0003);
    summarize();
  end
  initial begin
    repeat (10000) @(posedge i_clock);
    fails++;
    summarize();
  end
endmodule // elapsed_time_meter_tb
